// ### verilog/scd_clock_control.sv
// System clock divider control with slow mode, switch-back and stop select
//
// Overview of operation
// - Slow mode clear: divide by 1, 2, 4, 8 for select 00..11.
// - Slow mode set: all modules run at source rate over 256.
// - Every reset returns the divider to ratio 1.
// - Slow mode, switch-back on, programmed source active: slow mode clears itself.
// - While switch-back enable is 1 and a wake source is active, writes setting slow mode are ignored.
// - Switch-back acts only from divide-by-256 with switch-back enable at 1.
// - While slow mode is set, writes to both divide-select bits are blocked.
// - After switch-back or stop exit, run at the earlier divide-select ratio.
// - Enable 1 lets wake sources clear slow mode; enable 0 never does.
// - Wake source one: selected edge on an enabled external interrupt pin.
// - Masked external interrupt edges do not wake the clock.
// - Wake source two: receiver enabled and its input low (start bit).
// - Transmit activity also wakes; serial interrupt enable is irrelevant.
// - Wake source three: any SPI activity.
// - Wake source four: entry into active debug mode.
// - Writing 1 to stop select halts execution into stop state.
// - Stop select cleared by reset or enabled external interrupt; ratio unchanged.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module scd_clock_control (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [scd_pkg::SCD_EXT_INT_COUNT-1:0] ext_int_edge_i,
	input wire logic [scd_pkg::SCD_EXT_INT_COUNT-1:0] ext_int_enable_i,
	input wire logic serial_rx_enable_i,
	input wire logic serial_rxd_i,
	input wire logic serial_tx_busy_i,
	input wire logic spi_active_i,
	input wire logic debug_active_i,
	output logic sysclk_tick_o,
	output logic [3:0] div_shift_o,
	output logic slow_mode_o,
	output logic stop_mode_o,
	output logic switchback_o
);

	// ----------------------------------------------------------------
	// Wake source gathering
	// ----------------------------------------------------------------
	scd_pkg::scd_wake_s wake;
	logic ext_wake;
	logic serial_wake;
	logic any_source;

	always_comb begin
		wake.ext_edge = ext_int_edge_i;
		wake.ext_enable = ext_int_enable_i;
		wake.rx_enable = serial_rx_enable_i;
		wake.rx_line = serial_rxd_i;
		wake.tx_busy = serial_tx_busy_i;
		wake.spi_active = spi_active_i;
		wake.debug_active = debug_active_i;
	end

	// Only edges whose interrupt is really allowed count
	assign ext_wake = |(wake.ext_edge & wake.ext_enable);
	// No serial interrupt enable term on purpose
	assign serial_wake = (wake.rx_enable & ~wake.rx_line) | wake.tx_busy;
	assign any_source = ext_wake | serial_wake | wake.spi_active | wake.debug_active;

	// ----------------------------------------------------------------
	// Control register state
	// ----------------------------------------------------------------
	scd_pkg::scd_ctrl_s ctrl_reg;
	scd_pkg::scd_ctrl_s ctrl_next;
	logic switchback_reg;
	logic switchback_next;
	logic wr_hit;
	logic rd_hit;
	logic armed;
	logic lock_slow;

	assign wr_hit = reg_wr_i && (reg_addr_i == scd_pkg::SCD_ADDR_CLOCK_CONTROL);
	assign rd_hit = reg_rd_i && (reg_addr_i == scd_pkg::SCD_ADDR_CLOCK_CONTROL);
	// Switch-back needs slow mode already in force and the enable set
	assign armed = ctrl_reg.power_mgmt_enable && ctrl_reg.switchback_enable;
	assign lock_slow = ctrl_reg.switchback_enable && any_source;

	always_comb begin
		ctrl_next = ctrl_reg;
		switchback_next = 1'b0;
		if (wr_hit) begin
			ctrl_next.switchback_enable = reg_wdata_i[scd_pkg::SCD_BIT_SWITCHBACK_ENABLE];
			if (reg_wdata_i[scd_pkg::SCD_BIT_STOP_SELECT]) begin
				ctrl_next.stop_select = 1'b1;
			end
			if (!ctrl_reg.power_mgmt_enable) begin
				// Divide select frozen while slow, keeps the pre-slow ratio
				ctrl_next.div_select_hi = reg_wdata_i[scd_pkg::SCD_BIT_DIV_SELECT_HI];
				ctrl_next.div_select_lo = reg_wdata_i[scd_pkg::SCD_BIT_DIV_SELECT_LO];
			end
			if (reg_wdata_i[scd_pkg::SCD_BIT_POWER_MGMT_ENABLE]) begin
				if (!lock_slow) begin
					ctrl_next.power_mgmt_enable = 1'b1;
				end
			end else begin
				ctrl_next.power_mgmt_enable = 1'b0;
			end
		end
		// Hardware clear beats a simultaneous write
		if (armed && any_source) begin
			ctrl_next.power_mgmt_enable = 1'b0;
			switchback_next = 1'b1;
		end
		// Stop exit only touches the stop bit; ratio bits stay as they are
		if (ext_wake) begin
			ctrl_next.stop_select = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_reg <= scd_pkg::scd_ctrl_s'(scd_pkg::SCD_CTRL_RESET[4:0]);
			switchback_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			switchback_reg <= switchback_next;
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	always_comb begin
		rdata_next = scd_pkg::SCD_READ_UNMAPPED;
		if (rd_hit) begin
			rdata_next[scd_pkg::SCD_BIT_DIV_SELECT_LO] = ctrl_reg.div_select_lo;
			rdata_next[scd_pkg::SCD_BIT_DIV_SELECT_HI] = ctrl_reg.div_select_hi;
			rdata_next[scd_pkg::SCD_BIT_POWER_MGMT_ENABLE] = ctrl_reg.power_mgmt_enable;
			rdata_next[scd_pkg::SCD_BIT_SWITCHBACK_ENABLE] = ctrl_reg.switchback_enable;
			rdata_next[scd_pkg::SCD_BIT_STOP_SELECT] = ctrl_reg.stop_select;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_reg <= scd_pkg::SCD_READ_UNMAPPED;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// Divider
	// ----------------------------------------------------------------
	logic [3:0] shift_req;

	assign shift_req = scd_pkg::scd_shift_of(ctrl_reg);

	scd_divider u_divider (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.shift_req_i(shift_req),
		.tick_o(sysclk_tick_o),
		.shift_o(div_shift_o)
	);

	assign reg_rdata_o = rdata_reg;
	assign slow_mode_o = ctrl_reg.power_mgmt_enable;
	assign stop_mode_o = ctrl_reg.stop_select;
	assign switchback_o = switchback_reg;

endmodule : scd_clock_control

`default_nettype wire

// ### verilog/scd_pkg.sv
// Package: constants, types and helpers of the system clock divider control
package scd_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] SCD_ADDR_CLOCK_CONTROL = 8'h0E;
	localparam logic [7:0] SCD_CTRL_RESET = 8'h00;
	localparam logic [7:0] SCD_READ_UNMAPPED = 8'h00;

	// ----------------------------------------------------------------
	// Field positions of system_clock_control
	// ----------------------------------------------------------------
	localparam int unsigned SCD_BIT_DIV_SELECT_LO = 0;
	localparam int unsigned SCD_BIT_DIV_SELECT_HI = 1;
	localparam int unsigned SCD_BIT_POWER_MGMT_ENABLE = 2;
	localparam int unsigned SCD_BIT_SWITCHBACK_ENABLE = 3;
	localparam int unsigned SCD_BIT_STOP_SELECT = 4;

	// ----------------------------------------------------------------
	// Divide ratios as shift counts (ratio = 2 ** shift)
	// ----------------------------------------------------------------
	localparam logic [3:0] SCD_SHIFT_UNDIVIDED = 4'h0;
	localparam logic [3:0] SCD_SHIFT_SLOW = 4'h8;
	localparam int unsigned SCD_EXT_INT_COUNT = 4;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [SCD_EXT_INT_COUNT-1:0] ext_edge;
		logic [SCD_EXT_INT_COUNT-1:0] ext_enable;
		logic rx_enable;
		logic rx_line;
		logic tx_busy;
		logic spi_active;
		logic debug_active;
	} scd_wake_s;

	typedef struct packed {
		logic stop_select;
		logic switchback_enable;
		logic power_mgmt_enable;
		logic div_select_hi;
		logic div_select_lo;
	} scd_ctrl_s;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] scd_shift_of(input scd_ctrl_s ctrl);
		if (ctrl.power_mgmt_enable) begin
			scd_shift_of = SCD_SHIFT_SLOW;
		end else begin
			scd_shift_of = {2'h0, ctrl.div_select_hi, ctrl.div_select_lo};
		end
	endfunction : scd_shift_of

	function automatic logic [7:0] scd_last_count(input logic [3:0] shift);
		logic [8:0] span;
		span = 9'h001 << shift;
		scd_last_count = 8'(span - 9'h001);
	endfunction : scd_last_count

endpackage : scd_pkg

// ### verilog/scd_divider.sv
// Glitch-free clock enable divider that swaps ratio only on a period boundary
`timescale 1ns/100ps
`default_nettype none

module scd_divider (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] shift_req_i,
	output logic tick_o,
	output logic [3:0] shift_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic [3:0] shift_reg;
	logic [3:0] shift_next;
	logic tick_reg;
	logic tick_next;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		count_next = count_reg + 8'h01;
		shift_next = shift_reg;
		tick_next = 1'b0;
		// New ratio only at the end of a whole period, never mid-pulse
		if (count_reg == scd_pkg::scd_last_count(shift_reg)) begin
			count_next = 8'h00;
			shift_next = shift_req_i;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_reg <= 8'h00;
			shift_reg <= scd_pkg::SCD_SHIFT_UNDIVIDED;
			tick_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			shift_reg <= shift_next;
			tick_reg <= tick_next;
		end
	end

	assign tick_o = tick_reg;
	assign shift_o = shift_reg;

endmodule : scd_divider

`default_nettype wire

// ### dv/scd_clock_control_props.sv
// Port-level assertions of the system clock divider control
`timescale 1ns/100ps
`default_nettype none
module scd_clock_control_props (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic [scd_pkg::SCD_EXT_INT_COUNT-1:0] ext_int_edge_i,
	input wire logic [scd_pkg::SCD_EXT_INT_COUNT-1:0] ext_int_enable_i,
	input wire logic sysclk_tick_o,
	input wire logic [3:0] div_shift_o,
	input wire logic slow_mode_o,
	input wire logic stop_mode_o,
	input wire logic switchback_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic ext_hit = |(ext_int_edge_i & ext_int_enable_i);
	wire logic stop_wr = reg_wr_i && reg_addr_i == scd_pkg::SCD_ADDR_CLOCK_CONTROL &&
		reg_wdata_i[scd_pkg::SCD_BIT_STOP_SELECT];
	sequence s_slow_tick; sysclk_tick_o && div_shift_o == 4'h8; endsequence
	sequence s_gap_two; !sysclk_tick_o ##1 sysclk_tick_o; endsequence
	// Tick in the antecedent: the first edge after reset release carries no tick yet
	property p_ratio_one; sysclk_tick_o && div_shift_o == 4'h0 |=> sysclk_tick_o; endproperty
	a_ratio_one: assert property (p_ratio_one) else $error("tick missing at ratio one");
	property p_ratio_two; sysclk_tick_o && div_shift_o == 4'h1 |=> s_gap_two; endproperty
	a_ratio_two: assert property (p_ratio_two) else $error("bad period at ratio two");
	property p_slow_period; s_slow_tick |-> ##256 sysclk_tick_o; endproperty
	a_slow_period: assert property (p_slow_period) else $error("slow period not 256");
	property p_no_runt; s_slow_tick |=> !sysclk_tick_o [*8]; endproperty
	a_no_runt: assert property (p_no_runt) else $error("early tick in slow mode");
	property p_shift_on_tick; $changed(div_shift_o) |-> sysclk_tick_o; endproperty
	a_shift_on_tick: assert property (p_shift_on_tick) else $error("ratio changed mid period");
	property p_slow_shift; $past(slow_mode_o) && sysclk_tick_o |-> div_shift_o == 4'h8; endproperty
	a_slow_shift: assert property (p_slow_shift) else $error("slow mode not at 256");
	property p_switchback; switchback_o |-> $past(slow_mode_o) && !slow_mode_o; endproperty
	a_switchback: assert property (p_switchback) else $error("switch-back without slow mode");
	property p_stop_set; stop_wr && !ext_hit |=> stop_mode_o; endproperty
	a_stop_set: assert property (p_stop_set) else $error("stop select not set");
	property p_stop_clear; ext_hit |=> !stop_mode_o; endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stop select not cleared");
endmodule : scd_clock_control_props
`default_nettype wire

// ### dv/scd_clock_control_bench.sv
// Self-checking bench of the system clock divider control
`timescale 1ns/100ps
`default_nettype none
module scd_clock_control_bench;
	localparam logic [7:0] A = scd_pkg::SCD_ADDR_CLOCK_CONTROL;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [3:0] ext_int_edge_i = 4'h0;
	logic [3:0] ext_int_enable_i = 4'h0;
	logic serial_rx_enable_i = 1'b1;
	logic serial_rxd_i = 1'b1;
	logic serial_tx_busy_i = 1'b0;
	logic spi_active_i = 1'b0;
	logic debug_active_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic sysclk_tick_o, slow_mode_o, stop_mode_o, switchback_o;
	logic [3:0] div_shift_o;
	logic [3:0] pin = 4'h1;
	logic rd_dly = 1'b0;
	logic [15:0] exp_q[$];
	int miscompares = 0;
	int n_checks = 0;
	always #20 clk_i = ~clk_i;
	scd_clock_control scd_clock_control_inst (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .ext_int_edge_i, .ext_int_enable_i, .serial_rx_enable_i, .serial_rxd_i,
		.serial_tx_busy_i, .spi_active_i, .debug_active_i, .sysclk_tick_o, .div_shift_o, .slow_mode_o,
		.stop_mode_o, .switchback_o);
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic end_of_test;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		exp_q.push_back({8'h00, e});
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
	endtask : rd
	task automatic src(input int s, input logic v);
		case (s)
			0: ext_int_edge_i <= v ? pin : 4'h0;
			1: serial_rxd_i <= !v;
			2: serial_tx_busy_i <= v;
			3: spi_active_i <= v;
			default: debug_active_i <= v;
		endcase
	endtask : src
	task automatic pulse(input int s, input logic sb, input logic sl);
		@(posedge clk_i);
		src(s, 1'b1);
		@(posedge clk_i);
		src(s, 1'b0);
		#1;
		chk("switchback", {15'h0, sb}, {15'h0, switchback_o});
		chk("slow mode", {15'h0, sl}, {15'h0, slow_mode_o});
	endtask : pulse
	task automatic wt(input logic [3:0] k);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (!(sysclk_tick_o === 1'b1 && div_shift_o === k) && n < 600);
		chk("shift", {12'h0, k}, {12'h0, div_shift_o});
	endtask : wt
	task automatic per(input int e);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (sysclk_tick_o !== 1'b1 && n < 600);
		chk("period", 16'(e), 16'(n));
	endtask : per
	// ----------------------------------------------------------------
	// Read data monitor and watchdog
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rd_dly) chk("read data", exp_q.pop_front(), {8'h00, reg_rdata_o});
		rd_dly <= reg_rd_i;
	end
	initial begin
		#(40 * 50000);
		miscompares++;
		end_of_test();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h3cfe));
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(A, 8'h00);
		rd(8'h33, 8'h00);
		for (int k = 0; k < 4; k++) begin
			wr(A, 8'(k));
			wt(4'(k));
			per(1 << k);
		end
		wr(A, 8'h02);
		wr(A, 8'h0F);
		wr(A, 8'h0D);
		rd(A, 8'h0F);
		wt(4'h8);
		per(256);
		for (int s = 0; s < 5; s++) begin
			pin <= 4'h1 << $urandom_range(3);
			wr(A, 8'h0F);
			ext_int_enable_i <= pin;
			pulse(s, 1'b1, 1'b0);
			wt(4'h3);
		end
		wr(A, 8'h0F);
		ext_int_enable_i <= ~pin;
		pulse(0, 1'b0, 1'b1);
		@(posedge clk_i);
		serial_rx_enable_i <= 1'b0;
		pulse(1, 1'b0, 1'b1);
		@(posedge clk_i);
		serial_rx_enable_i <= 1'b1;
		ext_int_enable_i <= pin;
		wr(A, 8'h07);
		pulse(3, 1'b0, 1'b1);
		wr(A, 8'h0B);
		src(3, 1'b1);
		wr(A, 8'h0F);
		rd(A, 8'h0B);
		src(3, 1'b0);
		wt(4'h3);
		wr(A, 8'h13);
		#1;
		chk("stop", 16'h1, {15'h0, stop_mode_o});
		// Slow mode is off here, so the external edge only clears stop
		pulse(0, 1'b0, 1'b0);
		chk("stop", 16'h0, {15'h0, stop_mode_o});
		chk("shift", 16'h3, {12'h0, div_shift_o});
		repeat (4) @(posedge clk_i);
		end_of_test();
	end
endmodule : scd_clock_control_bench
bind scd_clock_control scd_clock_control_props props_inst (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
	.reg_wr_i, .ext_int_edge_i, .ext_int_enable_i, .sysclk_tick_o, .div_shift_o, .slow_mode_o,
	.stop_mode_o, .switchback_o);
`default_nettype wire
